// ---- include/glc_defs.vh ----
// constants for the gated load counter unit: offsets, fields, resets, timing
`ifndef GLC_DEFS_VH
`define GLC_DEFS_VH
// register map; channel block base = 0x100 + 0x20 * channel
`define GLC_CMD_OFS 12'h000
`define GLC_STAT_OFS 12'h004
`define GLC_PRE2_OFS 12'h008
`define GLC_CH_BASE 12'h100
`define GLC_CH_STRIDE 12'h020
`define GLC_CH_CFG 5'h00
`define GLC_CH_LOAD 5'h04
`define GLC_CH_COUNT 5'h08
`define GLC_CH_EVT 5'h0c
// command register fields (one-cycle write-only pulses)
`define GLC_CMD_START 0
`define GLC_CMD_STOP 8
`define GLC_CMD_LOAD 16
// channel configuration fields
`define GLC_CFG_DOWN 0
`define GLC_CFG_CYCLIC 1
`define GLC_CFG_GATE_EN 2
`define GLC_CFG_GATE_LVL 3
`define GLC_CFG_GATE_POL 4
`define GLC_CFG_CNT_LVL 5
`define GLC_CFG_SRC_LSB 8
`define GLC_CFG_SRC_MSB 10
`define GLC_CFG_COMB 11
`define GLC_CFG_HWLOAD 12
`define GLC_CFG_HWSTART 13
`define GLC_CFG_RST 32'h0000_0000
`define GLC_PRE2_RST 32'h0000_0000
// count source select codes
`define GLC_SRC_EXT 3'h0
`define GLC_SRC_P1A 3'h1
`define GLC_SRC_P1B 3'h2
`define GLC_SRC_P1C 3'h3
`define GLC_SRC_P2 3'h4
`define GLC_SRC_CASC 3'h5
// timing: reference 1 MHz derived from pclk 25 MHz
`define GLC_PCLK_MHZ 25
`define GLC_REF_MHZ 1
`define GLC_REF_DIV (`GLC_PCLK_MHZ / `GLC_REF_MHZ)
`endif

// ---- core/glc_counter_unit.v ----
// gated load counter unit: seven channels behind an apb register slave
// Function
// R1: up-counting adds one to the count per qualifying pulse.
// R2: down-counting starts from load register, subtracts one per pulse.
// R3: output toggles when a down-counting channel reaches zero.
// R4: software start copies load register into counter and runs.
// R5: one-time mode halts the channel on overflow or underflow.
// R6: halted one-time channel ignores pulses until next software start.
// R7: cyclic mode reloads from load register on range crossing.
// R8: cyclic channel keeps reloading without further start commands.
// R9: gated counting stops when the gate input is inactive.
// R10: an external process signal can start and gate a channel alone.
// R11: channels one to five switch by gate input or software commands.
// R12: loading of the start value may be triggered by an external input.
// R13: each channel has an event output for overflow or end of count.
// R14: events reach both a readable flag and the hardware output.
// R15: channels six and seven are 32 bits wide.
// R16: channels one to five each have their own gate input.
// R17: count and gate inputs qualify by edge or level, per input.
// R18: internal or external count sources, combinable with gating.
// R19: channels one to five cascade, previous output counts next.
// R20: first prescaler divides a 1 MHz reference into count sources.
// R21: second prescaler takes prescaler one or external inputs.
// R22: all exchange with the controller passes through shared memory.
// R23: channels six and seven decode quadrature pulse trains.
// R24: channels one to five are 16-bit general-purpose counters.
// R25: software stop holds the current count readable.
//
// Added by the designer: the APB register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "glc_defs.vh"
module glc_counter_unit #(
  parameter NCH = 7,
  parameter SW = 16,
  parameter QW = 32,
  parameter NSMALL = 5
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire [NCH-1:0] cnt_in,
  input wire [NCH-1:0] gate_in,
  input wire [NCH-1:0] load_in,
  input wire [1:0] quad_b_in,
  output wire [NCH-1:0] cnt_out,
  output wire [NCH-1:0] evt_out
);
  // register access completes in the access phase, no wait states
  assign pready = 1'b1;
  wire wr_acc = psel & penable & pwrite;
  wire rd_setup = psel & ~penable & ~pwrite;
  wire glob_hit = (paddr == `GLC_CMD_OFS) || (paddr == `GLC_STAT_OFS) ||
                  (paddr == `GLC_PRE2_OFS);
  wire [11:0] ch_rel = paddr - `GLC_CH_BASE;
  wire [2:0] ch_idx = ch_rel[7:5];
  wire ch_hit = (paddr >= `GLC_CH_BASE) && (ch_idx < NCH) &&
                (ch_rel[11:8] == 4'h0) && (ch_rel[1:0] == 2'b00) &&
                (ch_rel[4:0] <= `GLC_CH_EVT);
  assign pslverr = psel & penable & ~(glob_hit | ch_hit);
  wire cmd_wr = wr_acc && (paddr == `GLC_CMD_OFS);
  // prescaler 1: 1 MHz reference then two divide-by-1000 steps, each a one-cycle tick R20
  reg [4:0] ref_q;
  reg [9:0] dec_q;
  reg [9:0] dec2_q;
  wire ref_tick = (ref_q == `GLC_REF_DIV - 1);
  wire p1a = ref_tick;
  wire p1b = ref_tick && (dec_q == 10'd999);
  wire p1c = p1b && (dec2_q == 10'd999);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_q <= 5'h0;
      dec_q <= 10'h0;
      dec2_q <= 10'h0;
    end else begin
      ref_q <= ref_tick ? 5'h0 : ref_q + 5'd1; // R20
      if (ref_tick) begin
        dec_q <= (dec_q == 10'd999) ? 10'h0 : dec_q + 10'd1;
      end
      if (p1b) begin
        dec2_q <= (dec2_q == 10'd999) ? 10'h0 : dec2_q + 10'd1;
      end
    end
  end
  // input synchronisers: three flops, change counts when 2nd and 3rd agree
  reg [NCH-1:0] cs1_q, cs2_q, cs3_q, gs1_q, gs2_q, gs3_q, ls1_q, ls2_q, ls3_q;
  reg [NCH-1:0] cnt_f_q, gate_f_q, load_f_q;
  reg [1:0] qb1_q, qb2_q, qb3_q, qb_f_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cs1_q <= 0; cs2_q <= 0; cs3_q <= 0; cnt_f_q <= 0;
      gs1_q <= 0; gs2_q <= 0; gs3_q <= 0; gate_f_q <= 0;
      ls1_q <= 0; ls2_q <= 0; ls3_q <= 0; load_f_q <= 0;
      qb1_q <= 0; qb2_q <= 0; qb3_q <= 0; qb_f_q <= 0;
    end else begin
      cs1_q <= cnt_in; cs2_q <= cs1_q; cs3_q <= cs2_q;
      gs1_q <= gate_in; gs2_q <= gs1_q; gs3_q <= gs2_q;
      ls1_q <= load_in; ls2_q <= ls1_q; ls3_q <= ls2_q;
      qb1_q <= quad_b_in; qb2_q <= qb1_q; qb3_q <= qb2_q;
      cnt_f_q <= (cs2_q & ~(cs2_q ^ cs3_q)) | (cnt_f_q & (cs2_q ^ cs3_q));
      gate_f_q <= (gs2_q & ~(gs2_q ^ gs3_q)) | (gate_f_q & (gs2_q ^ gs3_q));
      load_f_q <= (ls2_q & ~(ls2_q ^ ls3_q)) | (load_f_q & (ls2_q ^ ls3_q));
      qb_f_q <= (qb2_q & ~(qb2_q ^ qb3_q)) | (qb_f_q & (qb2_q ^ qb3_q));
    end
  end
  reg [NCH-1:0] cnt_p_q, gate_p_q, load_p_q;
  reg [1:0] qb_p_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_p_q <= 0; gate_p_q <= 0; load_p_q <= 0; qb_p_q <= 0;
    end else begin
      cnt_p_q <= cnt_f_q; gate_p_q <= gate_f_q; load_p_q <= load_f_q;
      qb_p_q <= qb_f_q;
    end
  end
  // prescaler 2: divide selected source by programmable ratio R21
  reg [31:0] pre2_cfg_q;
  reg [15:0] pre2_cnt_q;
  reg p2_tick_q;
  reg p2_src;
  always @* begin
    case (pre2_cfg_q[19:16])
      4'h0: p2_src = p1a;
      4'h1: p2_src = p1b;
      4'h2: p2_src = p1c;
      4'h3: p2_src = cnt_f_q[0] & ~cnt_p_q[0];
      default: p2_src = gate_f_q[0] & ~gate_p_q[0];
    endcase
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre2_cnt_q <= 16'h0000;
      p2_tick_q <= 1'b0;
    end else begin
      p2_tick_q <= 1'b0;
      if (p2_src) begin
        if (pre2_cnt_q >= pre2_cfg_q[15:0]) begin
          pre2_cnt_q <= 16'h0000; // R21
          p2_tick_q <= 1'b1;
        end else begin
          pre2_cnt_q <= pre2_cnt_q + 16'd1;
        end
      end
    end
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre2_cfg_q <= `GLC_PRE2_RST;
    end else if (wr_acc && paddr == `GLC_PRE2_OFS) begin
      pre2_cfg_q <= pwdata;
    end
  end
  // per-channel state
  reg [31:0] cfg_q [0:NCH-1];
  reg [31:0] load_q [0:NCH-1];
  reg [31:0] cnt_q [0:NCH-1];
  reg [NCH-1:0] run_q, halt_q, tog_q, evt_q, ovf_q, zero_q;
  wire [NCH-1:0] wrap_w;
  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : ch
      localparam W = (g < NSMALL) ? SW : QW; // R15 R24
      localparam [31:0] MAXV = (W == 32) ? 32'hffff_ffff :
                               ((32'h1 << W) - 32'h1);
      wire [31:0] cfg = cfg_q[g];
      wire ch_wr = wr_acc && ch_hit && (ch_idx == g);
      wire c_edge = cnt_f_q[g] & ~cnt_p_q[g];
      wire c_q = cfg[`GLC_CFG_CNT_LVL] ? cnt_f_q[g] : c_edge; // R17
      wire g_raw = gate_f_q[g] ^ cfg[`GLC_CFG_GATE_POL];
      wire g_edge = g_raw & ~(gate_p_q[g] ^ cfg[`GLC_CFG_GATE_POL]);
      wire gate_ok = ~cfg[`GLC_CFG_GATE_EN] | g_raw; // R9 R16
      // level start fires only while idle, else it would reload every cycle
      wire hw_start = cfg[`GLC_CFG_HWSTART] &
                      (cfg[`GLC_CFG_GATE_LVL] ? (g_raw & ~run_q[g]) :
                       g_edge); // R10
      wire hw_load = cfg[`GLC_CFG_HWLOAD] &
                     load_f_q[g] & ~load_p_q[g]; // R12
      wire sw_start = cmd_wr & pwdata[`GLC_CMD_START + g];
      wire sw_stop = cmd_wr & pwdata[`GLC_CMD_STOP + g];
      wire sw_load = cmd_wr & pwdata[`GLC_CMD_LOAD + g];
      reg pulse;
      reg dn;
      always @* begin
        dn = cfg[`GLC_CFG_DOWN];
        pulse = 1'b0;
        if (g >= NSMALL) begin
          // quadrature: a edge on cnt, direction from b R23
          pulse = cnt_f_q[g] ^ cnt_p_q[g];
          dn = cnt_f_q[g] ^ qb_f_q[(g >= NSMALL) ? g - NSMALL : 0];
        end else begin
          case (cfg[`GLC_CFG_SRC_MSB:`GLC_CFG_SRC_LSB])
            `GLC_SRC_EXT: pulse = c_q;
            `GLC_SRC_P1A: pulse = p1a;
            `GLC_SRC_P1B: pulse = p1b;
            `GLC_SRC_P1C: pulse = p1c;
            `GLC_SRC_P2: pulse = p2_tick_q; // R21
            `GLC_SRC_CASC: pulse = (g > 0) ? wrap_w[(g+NCH-1)%NCH] : 1'b0; // R19
            default: pulse = 1'b0;
          endcase
          // combine internal timebase with external input as a qualifier
          if (cfg[`GLC_CFG_COMB]) begin
            pulse = pulse & cnt_f_q[g]; // R18
          end
        end
      end
      wire step = run_q[g] & gate_ok & pulse;
      wire at_lim = dn ? (cnt_q[g] == 32'h0) : (cnt_q[g] == MAXV);
      assign wrap_w[g] = step & at_lim;
      assign cnt_out[g] = tog_q[g];
      assign evt_out[g] = evt_q[g];
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cfg_q[g] <= `GLC_CFG_RST;
          load_q[g] <= 32'h0000_0000;
          cnt_q[g] <= 32'h0000_0000;
          run_q[g] <= 1'b0;
          halt_q[g] <= 1'b0;
          tog_q[g] <= 1'b0;
          evt_q[g] <= 1'b0;
          ovf_q[g] <= 1'b0;
          zero_q[g] <= 1'b0;
        end else begin
          evt_q[g] <= wrap_w[g]; // R13
          if (ch_wr && ch_rel[4:0] == `GLC_CH_CFG) begin
            cfg_q[g] <= pwdata;
          end
          if (ch_wr && ch_rel[4:0] == `GLC_CH_LOAD) begin
            load_q[g] <= pwdata & MAXV;
          end
          // sticky event flags, set wins over the write-one clear R14
          if (ch_wr && ch_rel[4:0] == `GLC_CH_EVT) begin
            ovf_q[g] <= ovf_q[g] & ~pwdata[0];
            zero_q[g] <= zero_q[g] & ~pwdata[1];
          end
          if (wrap_w[g]) begin
            ovf_q[g] <= 1'b1; // R14
          end
          if (step && dn && cnt_q[g] == 32'h1) begin
            zero_q[g] <= 1'b1;
            tog_q[g] <= ~tog_q[g]; // R3
          end
          if (sw_start | hw_start) begin
            cnt_q[g] <= load_q[g]; // R4 R2
            run_q[g] <= 1'b1; // R11
            halt_q[g] <= 1'b0;
          end else if (sw_stop) begin
            run_q[g] <= 1'b0; // R25 R11
          end else if (sw_load | hw_load) begin
            cnt_q[g] <= load_q[g]; // R12
          end else if (wrap_w[g]) begin
            if (cfg[`GLC_CFG_CYCLIC]) begin
              cnt_q[g] <= load_q[g]; // R7 R8
            end else begin
              run_q[g] <= 1'b0; // R5 R6
              halt_q[g] <= 1'b1;
            end
          end else if (step) begin
            cnt_q[g] <= dn ? cnt_q[g] - 32'h1 : cnt_q[g] + 32'h1; // R1 R2
          end
        end
      end
    end
  endgenerate
  // read data latched in setup; the register map is the shared memory R22
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata <= 32'h0000_0000;
      if (paddr == `GLC_STAT_OFS) begin
        prdata <= {{(16-NCH){1'b0}}, halt_q, {(16-NCH){1'b0}}, run_q};
      end else if (paddr == `GLC_PRE2_OFS) begin
        prdata <= pre2_cfg_q;
      end else if (ch_hit) begin
        case (ch_rel[4:0])
          `GLC_CH_CFG: prdata <= cfg_q[ch_idx];
          `GLC_CH_LOAD: prdata <= load_q[ch_idx];
          `GLC_CH_COUNT: prdata <= cnt_q[ch_idx];
          `GLC_CH_EVT: prdata <= {29'h0, tog_q[ch_idx], zero_q[ch_idx],
                                  ovf_q[ch_idx]};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule // glc_counter_unit
`default_nettype wire

// ---- verif/glc_counter_unit_assertions.sv ----
// checker: register bus and event output properties of the counter unit
`timescale 1ns/1ns
`default_nettype none
module glc_counter_unit_chk #(
  parameter NCH = 7
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire [NCH-1:0] cnt_out,
  input wire [NCH-1:0] evt_out
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wire acc = psel & penable;
  // only the gap below the channel blocks is tracked as unmapped
  wire hole = (paddr >= 12'h00C) && (paddr < 12'h100);
  a_ready_now: assert property (acc |-> pready)
    else $error("pready low in access phase");
  a_err_hole: assert property (acc && hole |-> pslverr)
    else $error("no error on unmapped access");
  a_err_mapped: assert property (acc && paddr == 12'h004 |-> !pslverr)
    else $error("error on mapped access");
  a_err_idle: assert property (!acc |-> !pslverr)
    else $error("error outside access phase");
  a_hole_zero: assert property (acc && hole && !pwrite |-> prdata == 0)
    else $error("unmapped read not zero");
  a_rdata_hold: assert property (!psel |=> $stable(prdata))
    else $error("read data moved while idle");
  a_evt_single: assert property (|evt_out |=> (evt_out & $past(evt_out)) == 0)
    else $error("event output longer than one cycle");
  a_reset_quiet: assert property ($rose(presetn) |-> evt_out == 0 && cnt_out == 0)
    else $error("outputs not quiet after reset");
  cover property (acc && hole);
  cover property ($rose(evt_out[4]));
  cover property ($changed(cnt_out[2]));
endmodule // glc_counter_unit_chk
bind glc_counter_unit glc_counter_unit_chk #(.NCH(NCH)) u_chk (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .cnt_out(cnt_out), .evt_out(evt_out));
`default_nettype wire

// ---- verif/glc_pulse_src.sv ----
// process side pulse source driving the count inputs
`timescale 1ns/1ns
`default_nettype none
module glc_pulse_src (
  input wire pclk,
  output logic [6:0] cnt_in,
  output logic [1:0] quad_b
);
  initial cnt_in = 7'h00;
  initial quad_b = 2'b00;
  // one full quadrature period with a leading a: two down steps
  task quad(input int ch, input int n);
    repeat (n) begin
      @(posedge pclk);
      cnt_in[ch] <= 1'b1;
      repeat (4) @(posedge pclk);
      quad_b[ch-5] <= 1'b1;
      repeat (4) @(posedge pclk);
      cnt_in[ch] <= 1'b0;
      repeat (4) @(posedge pclk);
      quad_b[ch-5] <= 1'b0;
      repeat (3) @(posedge pclk);
    end
  endtask
  // four cycles high and low: the pin filter swallows anything under two
  task pulses(input int ch, input int n);
    repeat (n) begin
      @(posedge pclk);
      cnt_in[ch] <= 1'b1;
      repeat (4) @(posedge pclk);
      cnt_in[ch] <= 1'b0;
      repeat (3) @(posedge pclk);
    end
  endtask
endmodule // glc_pulse_src
`default_nettype wire

// ---- verif/glc_counter_unit_tb.sv ----
// self-checking bench for the gated load counter unit
`timescale 1ns/1ns
`default_nettype none
`include "glc_defs.vh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin \
  mismatches++; $display("wrong value %s exp %h got %h", nm, e, g); end end
module glc_counter_unit_tb;
  typedef struct {int ch; logic [31:0] cfg; logic [31:0] ld; int np;
    logic [11:0] ra; logic [31:0] exp;} glc_row_t;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, q;
  logic [6:0] gate_in = 7'h00, load_in = 7'h00;
  wire [31:0] prdata;
  wire pready, pslverr;
  wire [6:0] cnt_in, cnt_out, evt_out;
  wire [1:0] quad_b;
  logic [6:0] evt_seen = 7'h00;
  int mismatches = 0;
  int n_tests = 0;
  glc_row_t rows [5] = '{
    '{0, 32'h0000_0000, 32'h0000_0010, 3, 12'h108, 32'h0000_0013},
    '{1, 32'h0000_0001, 32'h0000_0005, 2, 12'h128, 32'h0000_0003},
    '{2, 32'h0000_0001, 32'h0000_0001, 3, 12'h004, 32'h0004_0000},
    '{3, 32'h0000_0003, 32'h0000_0002, 4, 12'h168, 32'h0000_0001},
    '{4, 32'h0000_0000, 32'h0000_FFFF, 3, 12'h004, 32'h0014_0000}};
  glc_counter_unit uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .cnt_in(cnt_in),
    .gate_in(gate_in), .load_in(load_in), .quad_b_in(quad_b),
    .cnt_out(cnt_out), .evt_out(evt_out));
  glc_pulse_src src (.pclk(pclk), .cnt_in(cnt_in), .quad_b(quad_b));
  // event pulses last one cycle, so collect them
  always @(posedge pclk) evt_seen <= evt_seen | evt_out;
  always #20 pclk = ~pclk;
  function automatic logic [11:0] ca(input int ch, input logic [4:0] o);
    ca = 12'(`GLC_CH_BASE + `GLC_CH_STRIDE * ch + o);
  endfunction
  // held until pready is seen; one idle cycle keeps back-to-back calls apart
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task go(input int ch, input logic [31:0] cfg, input logic [31:0] ld);
    apb(1'b1, ca(ch, `GLC_CH_CFG), cfg);
    apb(1'b1, ca(ch, `GLC_CH_LOAD), ld);
    apb(1'b1, `GLC_CMD_OFS, 32'h0000_0001 << ch);
  endtask
  // pins need up to five cycles to take effect
  task settle;
    repeat (8) @(posedge pclk);
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (10000) @(posedge pclk);
    mismatches++;
    summarize();
  end
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, ca(0, `GLC_CH_CFG), 32'h0000_0000);
    `CHK("cfg reset", `GLC_CFG_RST, q)
    apb(1'b0, `GLC_PRE2_OFS, 32'h0000_0000);
    `CHK("pre2 reset", `GLC_PRE2_RST, q)
    foreach (rows[i]) begin
      go(rows[i].ch, rows[i].cfg, rows[i].ld);
      src.pulses(rows[i].ch, rows[i].np);
      settle();
      apb(1'b0, rows[i].ra, 32'h0000_0000);
      `CHK("row", rows[i].exp, q)
      apb(1'b1, `GLC_CMD_OFS, 32'h0000_0100 << rows[i].ch);
      if (rows[i].ch == 2)
        `CHK("zero toggle", 1'b1, cnt_out[2])
    end
    `CHK("events", 7'h1C, evt_seen)
    apb(1'b0, ca(4, `GLC_CH_EVT), 32'h0000_0000);
    `CHK("evt flags", 32'h0000_0001, q)
    apb(1'b1, 12'h00C, 32'hFFFF_FFFF);
    `CHK("hole err", 1'b1, err)
    apb(1'b0, 12'h00C, 32'h0000_0000);
    `CHK("hole read", 32'h0000_0000, q)
    go(0, 32'h0000_0000, 32'h0000_0000);
    src.pulses(0, 2);
    settle();
    apb(1'b1, `GLC_CMD_OFS, 32'h0000_0100);
    src.pulses(0, 2);
    settle();
    apb(1'b0, ca(0, `GLC_CH_COUNT), 32'h0000_0000);
    `CHK("stopped count", 32'h0000_0002, q)
    go(1, 32'h0000_0004, 32'h0000_0000);
    gate_in[1] <= 1'b1;
    src.pulses(1, 2);
    settle();
    gate_in[1] <= 1'b0;
    settle();
    src.pulses(1, 2);
    settle();
    apb(1'b0, ca(1, `GLC_CH_COUNT), 32'h0000_0000);
    `CHK("gated count", 32'h0000_0002, q)
    apb(1'b1, ca(2, `GLC_CH_CFG), 32'h0000_1000);
    apb(1'b1, ca(2, `GLC_CH_LOAD), 32'h0000_0007);
    load_in[2] <= 1'b1;
    repeat (4) @(posedge pclk);
    load_in[2] <= 1'b0;
    settle();
    apb(1'b0, ca(2, `GLC_CH_COUNT), 32'h0000_0000);
    `CHK("pin load", 32'h0000_0007, q)
    go(5, 32'h0000_0000, 32'h0001_0002);
    src.quad(5, 1);
    settle();
    apb(1'b0, ca(5, `GLC_CH_COUNT), 32'h0000_0000);
    `CHK("quad count", 32'h0001_0000, q)
    apb(1'b1, ca(3, `GLC_CH_CFG), 32'h0000_2000);
    apb(1'b1, ca(3, `GLC_CH_LOAD), 32'h0000_0005);
    gate_in[3] <= 1'b1;
    settle();
    src.pulses(3, 2);
    settle();
    apb(1'b0, ca(3, `GLC_CH_COUNT), 32'h0000_0000);
    `CHK("gate start", 32'h0000_0007, q)
    go(1, 32'h0000_0500, 32'h0000_0000);
    go(0, 32'h0000_0000, 32'h0000_FFFF);
    src.pulses(0, 1);
    settle();
    apb(1'b0, ca(1, `GLC_CH_COUNT), 32'h0000_0000);
    `CHK("cascade", 32'h0000_0001, q)
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    `CHK("reset toggles", 7'h00, cnt_out)
    apb(1'b0, ca(0, `GLC_CH_COUNT), 32'h0000_0000);
    `CHK("reset count", 32'h0000_0000, q)
    summarize();
  end
endmodule // glc_counter_unit_tb
`default_nettype wire
